// ==== hw/bat_pkg.sv ====
`default_nettype none
package bat_pkg;
	// apb register byte offsets
	localparam logic [7:0] BAT_OFF_CTRL = 8'h00;
	localparam logic [7:0] BAT_OFF_MASK = 8'h04;
	localparam logic [7:0] BAT_OFF_STAT = 8'h08;
	// control register fields
	localparam int BAT_CTRL_AMS    = 0;
	localparam int BAT_CTRL_SERREN = 1;
	localparam logic [1:0] BAT_CTRL_RST = 2'h0;
	// status bit positions, shared by status and mask
	localparam int BAT_ST_SEC_RMA  = 0;
	localparam int BAT_ST_SEC_RTA  = 1;
	localparam int BAT_ST_SEC_MDPE = 2;
	localparam int BAT_ST_SEC_SCD  = 3;
	localparam int BAT_ST_PRI_STA  = 4;
	localparam int BAT_ST_PRI_SSE  = 5;
	localparam int BAT_ST_PRI_RMA  = 6;
	localparam int BAT_ST_PRI_RTA  = 7;
	localparam int BAT_ST_SEC_STA  = 8;
	localparam int BAT_NST         = 9;
	localparam logic [BAT_NST-1:0] BAT_MASK_RST = 9'h000;
	// split completion message classes and indices
	localparam logic [3:0] BAT_CLS_OK   = 4'h0;
	localparam logic [3:0] BAT_CLS_BRG  = 4'h1;
	localparam logic [3:0] BAT_CLS_TGT  = 4'h2;
	localparam logic [7:0] BAT_IDX_00   = 8'h00;
	localparam logic [7:0] BAT_IDX_01   = 8'h01;
	localparam logic [7:0] BAT_IDX_02   = 8'h02;
	localparam logic [3:0] BAT_IDX_DEVHI = 4'h8;
	// termination / completion codes
	typedef enum logic [1:0] {BAT_CPL_OK, BAT_CPL_MA, BAT_CPL_TA} bat_cpl_type;
endpackage
`default_nettype wire

// ==== hw/bat_sticky.sv ====
`default_nettype none
module bat_sticky
	import bat_pkg::*;
#(
	parameter int W = 9
) (
	input  wire logic         mclk,
	input  wire logic         reset,
	input  wire logic [W-1:0] set,
	input  wire logic [W-1:0] clr,
	output var  logic [W-1:0] q
);
	// one sticky flag per bit, set wins over a same-cycle clear
	for (genvar i = 0; i < W; i++) begin : g_bit
		always_ff @(posedge mclk or posedge reset) begin
			if (reset) begin
				q[i] <= 1'b0;
			end else begin
				q[i] <= set[i] | (q[i] & ~clr[i]);
			end
		end
	end
endmodule
`default_nettype wire

// ==== hw/bat_top.sv ====
// Overview of operation
// - completion-required handling ignores abort mode and lock state.
// - aborted primary-initiated reads return all-ones data bytes.
// - immediate secondary abort forwarded upstream; sets matching status bits.
// - master data parity bit set only on real secondary parity error.
// - posted write abort: system-error message unless master abort with mode 0.
// - system-error message and signaled bit only when enable is set.
// - after returning an abort completion, secondary bus stays unlocked.
// - aborted split read completions return all-ones data.
// - class 0/1 split messages decode to success, master or target abort.
// - class 2 and illegal split messages return target abort upstream.
// - aborted downstream split completion raises system error, discarded bit.
// - upstream master abort ends conventional cycle with target abort.
// - upstream abort on PCI-X cycle gives split completion error message.
// - upstream target abort gives target abort or split target abort.
// - both aborts set both received bits and give target abort.
// - target abort only at initial connect or reconnect of master.
// - running read stream to conventional master is never cut.
// - abort with undelivered PCI-X data stops sequence, sends error message.
//
// Our own choices: the APB register port and the address map.
`default_nettype none
module bat_top
	import bat_pkg::*;
#(
	parameter int AW = 8,
	parameter int DW = 64
) (
	input  wire logic          mclk,
	input  wire logic          reset,
	input  wire logic [AW-1:0] paddr,
	input  wire logic          psel,
	input  wire logic          penable,
	input  wire logic          pwrite,
	input  wire logic [31:0]   pwdata,
	output var  logic [31:0]   prdata,
	output var  logic          pready,
	output var  logic          pslverr,
	input  wire logic          imm_vld,
	input  wire logic [1:0]    imm_code,
	input  wire logic          imm_posted,
	input  wire logic          imm_locked,
	input  wire logic          imm_par_err,
	input  wire logic          spl_vld,
	input  wire logic [3:0]    spl_class,
	input  wire logic [7:0]    spl_index,
	input  wire logic          spl_par_err,
	input  wire logic [DW-1:0] rd_data,
	input  wire logic          scd_vld,
	input  wire logic [1:0]    scd_code,
	input  wire logic          up_vld,
	input  wire logic          up_ma,
	input  wire logic          up_ta,
	input  wire logic          up_pcix,
	input  wire logic          up_connect,
	input  wire logic          up_streaming,
	input  wire logic          up_seq_running,
	output var  logic          cpl_vld,
	output var  logic [1:0]    cpl_code,
	output var  logic [DW-1:0] cpl_data,
	output var  logic          upstream_system_error_msg,
	output var  logic          sec_locked,
	output var  logic          sec_ta,
	output var  logic          spl_err_vld,
	output var  logic [1:0]    spl_err_code,
	output var  logic          seq_stop,
	output var  logic          irq
);
	// register select: 0 ctrl, 1 mask, 2 status, 3 unmapped
	function automatic logic [1:0] reg_sel(input logic [AW-1:0] a);
		logic [1:0] s;
		s = 2'h3;
		if (a == AW'(BAT_OFF_CTRL)) s = 2'h0;
		if (a == AW'(BAT_OFF_MASK)) s = 2'h1;
		if (a == AW'(BAT_OFF_STAT)) s = 2'h2;
		return s;
	endfunction

	logic [1:0]         ctrl_r;
	logic [BAT_NST-1:0] mask_r;
	logic [BAT_NST-1:0] st_q;
	logic [BAT_NST-1:0] st_set;
	logic [BAT_NST-1:0] st_clr;
	logic               wr_en;
	logic               ams;
	logic               serr_en;
	logic               serr_req;
	logic               cpl_vld_nxt;
	bat_cpl_type        cpl_nxt;
	logic               conv_abort;
	logic               pend_r;
	bat_cpl_type        imm_c;
	bat_cpl_type        scd_c;

	assign imm_c   = bat_cpl_type'(imm_code);
	assign scd_c   = bat_cpl_type'(scd_code);
	assign ams     = ctrl_r[BAT_CTRL_AMS];
	assign serr_en = ctrl_r[BAT_CTRL_SERREN];
	assign wr_en   = psel & penable & pready & pwrite;
	assign st_clr  = (wr_en && reg_sel(paddr) == 2'h2) ? pwdata[BAT_NST-1:0] : '0;
	assign conv_abort = up_vld & ~up_pcix & (up_ma | up_ta);

	// apb answer one cycle into the access phase
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & (reg_sel(paddr) == 2'h3);
			unique case (reg_sel(paddr))
				2'h0: prdata <= {30'h0, ctrl_r};
				2'h1: prdata <= {23'h0, mask_r};
				2'h2: prdata <= {23'h0, st_q};
				2'h3: prdata <= 32'h0000_0000;
			endcase
		end
	end

	// control and mask registers
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			ctrl_r <= BAT_CTRL_RST;
			mask_r <= BAT_MASK_RST;
		end else if (wr_en) begin
			if (reg_sel(paddr) == 2'h0) ctrl_r <= pwdata[1:0];
			if (reg_sel(paddr) == 2'h1) mask_r <= pwdata[BAT_NST-1:0];
		end
	end

	// termination decode: status sets, completion, system error request
	always_comb begin
		st_set      = '0;
		serr_req    = 1'b0;
		cpl_vld_nxt = 1'b0;
		cpl_nxt     = BAT_CPL_OK;
		// immediate secondary termination; lock state not consulted
		if (imm_vld) begin
			st_set[BAT_ST_SEC_MDPE] = imm_par_err;
			if (!imm_posted) begin
				cpl_vld_nxt = 1'b1;
				cpl_nxt     = imm_c;
				if (imm_c == BAT_CPL_MA) st_set[BAT_ST_SEC_RMA] = 1'b1;
				if (imm_c == BAT_CPL_TA) begin
					st_set[BAT_ST_SEC_RTA] = 1'b1;
					st_set[BAT_ST_PRI_STA] = 1'b1;
				end
			end else begin
				if (imm_c == BAT_CPL_MA) begin
					st_set[BAT_ST_SEC_RMA] = 1'b1;
					serr_req = ams;
				end
				if (imm_c == BAT_CPL_TA) begin
					st_set[BAT_ST_SEC_RTA] = 1'b1;
					serr_req = 1'b1;
				end
			end
		end else if (spl_vld) begin
			// split completion message decode
			cpl_vld_nxt = 1'b1;
			cpl_nxt     = BAT_CPL_TA;
			st_set[BAT_ST_PRI_STA] = 1'b1;
			if (spl_class == BAT_CLS_OK && spl_index == BAT_IDX_00) begin
				cpl_nxt = BAT_CPL_OK;
				st_set[BAT_ST_PRI_STA] = 1'b0;
				st_set[BAT_ST_SEC_MDPE] = spl_par_err;
			end else if (spl_class == BAT_CLS_BRG && spl_index == BAT_IDX_00) begin
				cpl_nxt = BAT_CPL_MA;
				st_set[BAT_ST_PRI_STA] = 1'b0;
				st_set[BAT_ST_SEC_RMA] = 1'b1;
			end else if (spl_class == BAT_CLS_BRG && spl_index == BAT_IDX_01) begin
				st_set[BAT_ST_SEC_RTA] = 1'b1;
			end else if (spl_class == BAT_CLS_BRG && spl_index == BAT_IDX_02) begin
				st_set[BAT_ST_SEC_MDPE] = 1'b1;
			end else if (spl_class == BAT_CLS_TGT && spl_index == BAT_IDX_01) begin
				st_set[BAT_ST_SEC_MDPE] = 1'b1;
			end
		end
		// downstream split completion aborted at once
		if (scd_vld && scd_c != BAT_CPL_OK) begin
			st_set[BAT_ST_SEC_SCD] = 1'b1;
			serr_req = 1'b1;
			if (scd_c == BAT_CPL_MA) st_set[BAT_ST_SEC_RMA] = 1'b1;
			if (scd_c == BAT_CPL_TA) st_set[BAT_ST_SEC_RTA] = 1'b1;
		end
		// upstream termination of secondary-initiated cycle
		if (up_vld) begin
			if (up_ma) st_set[BAT_ST_PRI_RMA] = 1'b1;
			if (up_ta) st_set[BAT_ST_PRI_RTA] = 1'b1;
			if (up_ta || (up_ma && !up_pcix)) st_set[BAT_ST_SEC_STA] = 1'b1;
		end
		st_set[BAT_ST_PRI_SSE] = serr_req & serr_en;
	end

	bat_sticky #(
		.W (BAT_NST)
	) u_stat (
		.mclk  (mclk),
		.reset (reset),
		.set   (st_set),
		.clr   (st_clr),
		.q     (st_q)
	);

	// upstream completion with all-ones fill on abort
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			cpl_vld  <= 1'b0;
			cpl_code <= 2'h0;
			cpl_data <= '0;
		end else begin
			cpl_vld  <= cpl_vld_nxt;
			cpl_code <= cpl_nxt;
			cpl_data <= (cpl_nxt != BAT_CPL_OK) ? '1 : rd_data;
		end
	end

	// system error message pulse, gated by enable
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			upstream_system_error_msg <= 1'b0;
		end else begin
			upstream_system_error_msg <= serr_req & serr_en;
		end
	end

	// secondary lock tracking, dropped by any abort completion
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			sec_locked <= 1'b0;
		end else if (cpl_vld_nxt && cpl_nxt != BAT_CPL_OK) begin
			sec_locked <= 1'b0;
		end else if (imm_vld && !imm_posted && imm_locked && imm_c == BAT_CPL_OK) begin
			sec_locked <= 1'b1;
		end
	end

	// conventional target abort held until connect outside a stream
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			pend_r <= 1'b0;
			sec_ta <= 1'b0;
		end else begin
			sec_ta <= pend_r & up_connect & ~up_streaming;
			if (conv_abort) begin
				pend_r <= 1'b1;
			end else if (up_connect && !up_streaming) begin
				pend_r <= 1'b0;
			end
		end
	end

	// pci-x split completion error message and sequence stop
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			spl_err_vld  <= 1'b0;
			spl_err_code <= 2'h0;
			seq_stop     <= 1'b0;
		end else begin
			spl_err_vld  <= up_vld & up_pcix & (up_ma | up_ta);
			spl_err_code <= up_ta ? BAT_CPL_TA : BAT_CPL_MA;
			seq_stop     <= up_vld & up_pcix & (up_ma | up_ta) & up_seq_running;
		end
	end

	// level interrupt from masked status
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			irq <= 1'b0;
		end else begin
			irq <= |((st_set | (st_q & ~st_clr)) & mask_r);
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	sequence s_imm_abort_rd;
		imm_vld && !imm_posted && imm_c != BAT_CPL_OK;
	endsequence
	sequence s_ones_out;
		cpl_vld && cpl_data == '1;
	endsequence
	property p_abort_ones;
		s_imm_abort_rd |-> ##1 s_ones_out;
	endproperty
	a_abort_ones: assert property (p_abort_ones)
		else $error("aborted read not filled with ones");

	sequence s_imm_ta;
		imm_vld && !imm_posted && imm_c == BAT_CPL_TA;
	endsequence
	property p_imm_ta;
		s_imm_ta |-> ##1 (cpl_code == BAT_CPL_TA && st_q[BAT_ST_PRI_STA] && st_q[BAT_ST_SEC_RTA]);
	endproperty
	a_imm_ta: assert property (p_imm_ta)
		else $error("immediate target abort not forwarded");

	property p_posted_ma0;
		imm_vld && imm_posted && imm_c == BAT_CPL_MA && !ams && !scd_vld
			|=> !upstream_system_error_msg && st_q[BAT_ST_SEC_RMA];
	endproperty
	a_posted_ma0: assert property (p_posted_ma0)
		else $error("posted master abort with mode 0 raised system error");

	property p_serr_gate;
		upstream_system_error_msg |-> $past(serr_en) && st_q[BAT_ST_PRI_SSE];
	endproperty
	a_serr_gate: assert property (p_serr_gate)
		else $error("system error message without enable");

	property p_spl_ma;
		spl_vld && !imm_vld && spl_class == BAT_CLS_BRG && spl_index == BAT_IDX_00
			|-> ##1 (cpl_code == BAT_CPL_MA && st_q[BAT_ST_SEC_RMA]);
	endproperty
	a_spl_ma: assert property (p_spl_ma)
		else $error("split master abort message misdecoded");

	property p_spl_cls2;
		spl_vld && !imm_vld && spl_class == BAT_CLS_TGT
			|-> ##1 (cpl_vld && cpl_code == BAT_CPL_TA && st_q[BAT_ST_PRI_STA]);
	endproperty
	a_spl_cls2: assert property (p_spl_cls2)
		else $error("class 2 message not returned as target abort");

	property p_scd;
		scd_vld && scd_c != BAT_CPL_OK |=> st_q[BAT_ST_SEC_SCD] && (upstream_system_error_msg == $past(serr_en));
	endproperty
	a_scd: assert property (p_scd)
		else $error("discarded split completion not reported");

	property p_conv_ma;
		up_vld && up_ma && !up_pcix |=> st_q[BAT_ST_PRI_RMA] && st_q[BAT_ST_SEC_STA] && pend_r;
	endproperty
	a_conv_ma: assert property (p_conv_ma)
		else $error("conventional master abort not converted");

	property p_no_cut;
		sec_ta |-> !$past(up_streaming) && $past(up_connect);
	endproperty
	a_no_cut: assert property (p_no_cut)
		else $error("target abort signalled inside a stream");

	property p_seq_stop;
		up_vld && up_pcix && up_ta && up_seq_running |=> seq_stop && spl_err_vld && spl_err_code == BAT_CPL_TA;
	endproperty
	a_seq_stop: assert property (p_seq_stop)
		else $error("pci-x sequence not stopped on abort");

	property p_unlock;
		cpl_vld && cpl_code != BAT_CPL_OK |-> !sec_locked;
	endproperty
	a_unlock: assert property (p_unlock)
		else $error("bus left locked after abort completion");

	property p_sticky;
		(|($past(st_q) & ~st_q & ~$past(st_clr))) == 1'b0;
	endproperty
	a_sticky: assert property (p_sticky)
		else $error("status bit dropped without software clear");
endmodule
`default_nettype wire

// ==== tb/bat_far_model.sv ====
`default_nettype none
module bat_far_model
	import bat_pkg::*;
#(
	parameter int DW = 64
) (
	input  wire logic          mclk,
	output var  logic          imm_vld,
	output var  logic [1:0]    imm_code,
	output var  logic          imm_posted,
	output var  logic          imm_locked,
	output var  logic          imm_par_err,
	output var  logic          spl_vld,
	output var  logic [3:0]    spl_class,
	output var  logic [7:0]    spl_index,
	output var  logic          spl_par_err,
	output var  logic [DW-1:0] rd_data,
	output var  logic          scd_vld,
	output var  logic [1:0]    scd_code,
	output var  logic          up_vld,
	output var  logic          up_ma,
	output var  logic          up_ta,
	output var  logic          up_pcix
);
	timeunit 1ns;
	timeprecision 1ns;
	// quiet side at time zero
	initial begin
		{imm_vld, imm_code, imm_posted, imm_locked, imm_par_err, spl_vld} = '0;
		{spl_class, spl_index, spl_par_err, scd_vld, scd_code} = '0;
		{up_vld, up_ma, up_ta, up_pcix, rd_data} = '0;
	end
	// immediate termination of a primary-initiated cycle
	task automatic imm(input logic [1:0] k, input logic p, l, e, input logic [DW-1:0] d);
		imm_code <= k;
		imm_posted <= p;
		imm_locked <= l;
		imm_par_err <= e;
		rd_data <= d;
		imm_vld <= 1'b1;
		@(posedge mclk);
		imm_vld <= 1'b0;
		rd_data <= ~d; // stale word never matches by luck
	endtask
	// split completion message
	task automatic spl(input logic [3:0] c, input logic [7:0] x, input logic e,
		input logic [DW-1:0] d);
		spl_class <= c;
		spl_index <= x;
		spl_par_err <= e;
		rd_data <= d;
		spl_vld <= 1'b1;
		@(posedge mclk);
		spl_vld <= 1'b0;
		rd_data <= ~d; // stale word never matches by luck
	endtask
	// downstream split completion refused
	task automatic scd(input logic [1:0] k);
		scd_code <= k;
		scd_vld <= 1'b1;
		@(posedge mclk);
		scd_vld <= 1'b0;
	endtask
	// upstream termination of a secondary cycle
	task automatic up(input logic m, t, x);
		up_ma <= m;
		up_ta <= t;
		up_pcix <= x;
		up_vld <= 1'b1;
		@(posedge mclk);
		up_vld <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ==== tb/bat_top_tb_top.sv ====
`default_nettype none
module bat_top_tb_top
	import bat_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0]  paddr, spl_index;
	logic [31:0] pwdata, prdata, q, j;
	logic [63:0] rd_data, cpl_data, d;
	logic [1:0]  imm_code, cpl_code, scd_code, spl_err_code, c, k;
	logic [3:0]  spl_class;
	logic [8:0]  s;
	logic [10:0] x;
	logic [11:0] sc;
	logic        mclk = 1'b0, reset, psel, penable, pwrite, pready, pslverr, e, p, lk;
	logic        imm_vld, imm_posted, imm_locked, imm_par_err, spl_vld, spl_par_err;
	logic        up_vld, up_ma, up_ta, up_pcix, up_connect, up_streaming, up_seq_running;
	logic        cpl_vld, upstream_system_error_msg, sec_locked, sec_ta, irq, scd_vld;
	logic        spl_err_vld, seq_stop;
	int          n_mismatch, num_checks, i;
	int          cyc = 0;
	logic [11:0] tbl [10] = '{12'h000, 12'h100, 12'h101, 12'h102, 12'h200, 12'h201,
		12'h280, 12'h005, 12'h1f0, 12'h300};

	bat_top dut (.mclk, .reset, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
		.pslverr, .imm_vld, .imm_code, .imm_posted, .imm_locked, .imm_par_err, .spl_vld,
		.spl_class, .spl_index, .spl_par_err, .rd_data, .scd_vld, .scd_code, .up_vld, .up_ma,
		.up_ta, .up_pcix, .up_connect, .up_streaming, .up_seq_running, .cpl_vld, .cpl_code,
		.cpl_data, .upstream_system_error_msg, .sec_locked, .sec_ta, .spl_err_vld,
		.spl_err_code, .seq_stop, .irq);
	bat_far_model far (.mclk, .imm_vld, .imm_code, .imm_posted, .imm_locked, .imm_par_err,
		.spl_vld, .spl_class, .spl_index, .spl_par_err, .rd_data, .scd_vld, .scd_code,
		.up_vld, .up_ma, .up_ta, .up_pcix);

	// 100 ns clock
	always #50 mclk = ~mclk;
	// hang guard
	always @(posedge mclk) begin
		cyc++;
		if (cyc > 20000) begin
			n_mismatch++;
			stop_test();
		end
	end
	task automatic stop_test;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [127:0] got, exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("FAIL %s expected %0h seen %0h", nm, exp, got);
		end
	endtask
	// one apb transfer, then an idle cycle
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		paddr <= a;
		pwrite <= w;
		pwdata <= wd;
		psel <= 1'b1;
		@(posedge mclk);
		penable <= 1'b1;
		@(posedge mclk);
		while (pready !== 1'b1)
			@(posedge mclk);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask
	// clear status, load control
	task automatic setup(input logic [1:0] cc);
		apb(1'b1, BAT_OFF_STAT, 32'h0000_01ff);
		apb(1'b1, BAT_OFF_CTRL, {30'h0, cc});
	endtask
	// outputs and status after one event
	task automatic settle(input logic v, input logic [1:0] kk, input logic [63:0] a,
		input logic [9:0] xx);
		#1;
		chk("completion", {cpl_vld, cpl_vld ? {cpl_code, cpl_data} : 66'h0},
			{v, v ? {kk, a} : 66'h0});
		chk("system error msg", upstream_system_error_msg, xx[9]);
		if (v)
			chk("lock", sec_locked, lk);
		@(posedge mclk);
		apb(1'b0, BAT_OFF_STAT, 32'h0);
		chk("status", q, {23'h0, xx[8:0]});
	endtask
	// expected {message, status} of an immediate termination
	function automatic logic [9:0] imm_exp(input logic [1:0] kk, input logic pp, pe,
		input logic [1:0] cc);
		logic [9:0] r;
		r = '0;
		r[BAT_ST_SEC_MDPE] = pe;
		r[BAT_ST_SEC_RMA] = (kk == 2'h1);
		r[BAT_ST_SEC_RTA] = (kk == 2'h2);
		r[BAT_ST_PRI_STA] = (kk == 2'h2) && !pp;
		r[9] = pp && cc[1] && (kk == 2'h2 || (kk == 2'h1 && cc[0]));
		r[BAT_ST_PRI_SSE] = r[9];
		return r;
	endfunction
	// expected {code, status} of a split message
	function automatic logic [10:0] spl_exp(input logic [3:0] cl, input logic [7:0] ix,
		input logic pe);
		logic [8:0] r;
		r = '0;
		if (cl == 4'h0 && ix == 8'h00) begin
			r[BAT_ST_SEC_MDPE] = pe;
			return {2'(BAT_CPL_OK), r};
		end
		if (cl == 4'h1 && ix == 8'h00) begin
			r[BAT_ST_SEC_RMA] = 1'b1;
			return {2'(BAT_CPL_MA), r};
		end
		r[BAT_ST_PRI_STA] = 1'b1;
		r[BAT_ST_SEC_RTA] = (cl == 4'h1 && ix == 8'h01);
		r[BAT_ST_SEC_MDPE] = (cl == 4'h1 && ix == 8'h02) || (cl == 4'h2 && ix == 8'h01);
		return {2'(BAT_CPL_TA), r};
	endfunction
	// upstream connect, expecting a target abort or not
	task automatic conn(input logic st, input logic xs);
		up_streaming <= st;
		up_connect <= 1'b1;
		@(posedge mclk);
		up_connect <= 1'b0;
		#1;
		chk("target abort", sec_ta, xs);
		@(posedge mclk);
	endtask

	// main sequence
	initial begin
		{psel, penable, pwrite, paddr, pwdata, up_connect, up_streaming, up_seq_running} = '0;
		reset = 1'b1;
		lk = 1'b0;
		j = $urandom(58);
		repeat (20) @(posedge mclk);
		reset <= 1'b0;
		@(posedge mclk);
		for (i = 0; i < 4; i++) begin
			apb(1'b0, 8'(i * 4), 32'h0);
			chk("reset read", {e, q}, {i == 3, 32'h0});
		end
		for (i = 0; i < 24; i++) begin
			k = 2'(i % 3);
			p = 1'((i / 3) % 2);
			c = 2'(i / 6);
			setup(c);
			j = $urandom;
			d = {$urandom, $urandom};
			far.imm(k, p, j[0] | j[1], j[2], d);
			if (!p)
				lk = (k == 2'h0) && (lk || j[0] || j[1]); // lock held until an abort
			settle(!p, k, (k == 2'h0) ? d : '1, imm_exp(k, p, j[2], c));
		end
		for (i = 0; i < 10; i++) begin
			j = $urandom;
			sc = tbl[i];
			if (i == 6)
				sc[3:0] = 4'(j);
			if (i == 9)
				sc[11:8] = 4'(3 + j % 13);
			far.imm(2'h0, 1'b0, 1'b1, 1'b0, d);
			setup(2'(j));
			x = spl_exp(sc[11:8], sc[7:0], j[4]);
			lk = (x[10:9] == 2'h0);
			d = {$urandom, $urandom};
			far.spl(sc[11:8], sc[7:0], j[4], d);
			settle(1'b1, x[10:9], lk ? d : '1, {1'b0, x[8:0]});
		end
		for (i = 0; i < 6; i++) begin
			k = 2'(i % 3);
			c = {1'(i / 3), 1'b0};
			setup(c);
			s = '0;
			s[BAT_ST_SEC_RMA] = (k == 2'h1);
			s[BAT_ST_SEC_RTA] = (k == 2'h2);
			s[BAT_ST_SEC_SCD] = (k != 2'h0);
			s[BAT_ST_PRI_SSE] = (k != 2'h0) && c[1];
			far.scd(k);
			settle(1'b0, k, d, {s[BAT_ST_PRI_SSE], s});
		end
		conn(1'b0, 1'b0);
		for (i = 0; i < 6; i++) begin
			j = $urandom;
			k = 2'(i % 3 + 1);
			setup(2'h0);
			up_seq_running <= j[0];
			far.up(k[1], k[0], i > 2);
			#1;
			chk("split error", {spl_err_vld, spl_err_vld ? spl_err_code : 2'h0, seq_stop},
				{i > 2, (i > 2) ? (k[0] ? 2'h2 : 2'h1) : 2'h0, i > 2 && j[0]});
			@(posedge mclk);
			conn(1'b1, 1'b0);
			conn(1'b0, i < 3);
			s = '0;
			s[BAT_ST_PRI_RMA] = k[1];
			s[BAT_ST_PRI_RTA] = k[0];
			s[BAT_ST_SEC_STA] = k[0] || i < 3;
			apb(1'b0, BAT_OFF_STAT, 32'h0);
			chk("status", q, {23'h0, s});
		end
		setup(2'h0);
		far.scd(2'h1);
		@(posedge mclk);
		far.scd(2'h2);
		chk("irq masked", irq, 1'b0);
		apb(1'b1, BAT_OFF_MASK, 32'h0000_0008);
		#1;
		chk("irq", irq, 1'b1);
		@(posedge mclk);
		apb(1'b1, BAT_OFF_STAT, 32'h0000_0001);
		apb(1'b0, BAT_OFF_STAT, 32'h0);
		chk("sticky status", q, 32'h0000_000a);
		apb(1'b1, BAT_OFF_STAT, 32'h0000_0008);
		#1;
		chk("irq cleared", irq, 1'b0);
		stop_test();
	end
endmodule
`default_nettype wire
